// [verilog/fpu_add_compare_consts.vh]
// Purpose: constants of the floating-point add and compare unit
// Assumes: included by fpu_add_compare_unit.v and by the testbench files, guarded against repeats
// Notes:   byte offsets on a 32-bit apb, fields of the status/control word
`ifndef FPU_ADD_COMPARE_CONSTS_VH
`define FPU_ADD_COMPARE_CONSTS_VH

// register byte offsets
`define OFF_STATUS_CTRL 8'h00
`define OFF_DEST_HI 8'h04
`define OFF_DEST_LO 8'h08
`define OFF_SRC_HI 8'h0c
`define OFF_SRC_LO 8'h10
`define OFF_COMMAND 8'h14
`define OFF_UNIT_STATE 8'h18
`define OFF_PROG_COUNTER 8'h1c
`define OFF_IRQ_STATUS 8'h20
`define OFF_IRQ_ENABLE 8'h24
`define OFF_IRQ_CLEAR 8'h28

// status/control word fields
`define RM_LO 0
`define RM_HI 1
`define FLAG_LO 2
`define FLAG_HI 6
`define ENABLE_LO 7
`define ENABLE_HI 11
`define CAUSE_LO 12
`define CAUSE_HI 17
`define DN_BIT 18
`define PR_BIT 19

// exception bit positions inside flag, enable and cause fields; E exists in the cause field only
`define EXC_I 0
`define EXC_U 1
`define EXC_O 2
`define EXC_Z 3
`define EXC_V 4
`define EXC_E 5

// instruction encodings: top nibble and low nibble
`define OPC_PREFIX 4'hf
`define OPC_ADD 4'h0
`define OPC_CMP_EQ 4'h4
`define OPC_CMP_GT 4'h5

// execution states per instruction
`define STATES_ADD_SINGLE 3'd1
`define STATES_ADD_DOUBLE 3'd6
`define STATES_CMP_EQ 3'd1
`define STATES_CMP_GT 3'd2
`define PC_STEP 32'h0000_0002

// operand classes
`define CLS_NORM 3'd0
`define CLS_ZERO 3'd1
`define CLS_INF 3'd2
`define CLS_DENORM 3'd3
`define CLS_QNAN 3'd4
`define CLS_SNAN 3'd5

// default quiet nans and number format constants
`define QNAN_SINGLE 32'h7fbf_ffff
`define QNAN_DOUBLE 64'h7ff7_ffff_ffff_ffff
`define REBIAS 12'd896
`define EMAX_DOUBLE 13'd2047
`define EMAX_SINGLE 13'd255
`define RESET_STATUS 20'h0_0000

`endif

// [verilog/fpu_add_compare_unit.v]
// Purpose: add and equal/greater compare in single or double precision
// Assumes: apb master on ref_clk; single operands in the low words
// Notes:   one command in flight; add results land in the dest registers, compare results in condBit
//
// The address map and the APB register port were decided locally.
`timescale 1ns/10ps
`include "fpu_add_compare_consts.vh"

// What this block does
// RULE1: single add writes destination in one state
// RULE2: double add writes destination pair, six states
// RULE3: any O/U/I enable traps every add
// RULE4: exceptions update cause, and flags except E; destination kept when trapped
// RULE5: each instruction clears cause, program counter plus two
// RULE6: signalling nan invalid, else quiet nan result
// RULE7: denormal gives error unless treated as zero
// RULE8: opposite infinities invalid, otherwise infinity wins
// RULE9: zero plus normal gives normal; zeros combine
// RULE10: add raises only E, V, O, U, I
// RULE11: equal compare sets condition, one state
// RULE12: greater compare sets condition, two states
// RULE13: signalling nan compare: invalid, clear or trap
// RULE14: greater with quiet nan takes invalid path
// RULE15: equal with quiet nan: not equal, no invalid
// RULE16: positive and negative zero compare equal
// RULE17: infinities order against finite, equal to themselves
// RULE18: finite compare uses selected precision operands
// RULE19: normal sum rounded, O/U/I flags from result
module fpu_add_compare_unit (
    // clock and reset
    input  wire        ref_clk,
    input  wire        sys_rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    // unit status
    output wire        irq,
    output reg         busy,
    output reg         condBit
);

    // classify one operand, denormal folds to zero when dn is set
    function [2:0] classify(input [63:0] v, input prec, input dn);
        reg eAll1, eZero, fZero, fTop;
        begin
            eAll1 = prec ? (v[62:52] == 11'h7ff) : (v[30:23] == 8'hff);
            eZero = prec ? (v[62:52] == 11'h000) : (v[30:23] == 8'h00);
            fZero = prec ? (v[51:0] == 52'h0) : (v[22:0] == 23'h0);
            fTop  = prec ? v[51] : v[22];
            if (eAll1)
                classify = fZero ? `CLS_INF : (fTop ? `CLS_SNAN : `CLS_QNAN);
            else if (eZero)
                classify = (fZero | dn) ? `CLS_ZERO : `CLS_DENORM;
            else
                classify = `CLS_NORM;
        end
    endfunction

    // count leading zeros of the unrounded sum
    function [5:0] lzc56(input [55:0] v);
        integer i;
        integer n;
        reg     found;
        begin
            n = 56;
            found = 1'b0;
            for (i = 55; i >= 0; i = i - 1) begin
                if (!found && v[i]) begin
                    n = 55 - i;
                    found = 1'b1;
                end
            end
            lzc56 = n[5:0];
        end
    endfunction

    // apb handshake and register state
    wire        setup   = psel & ~penable; // address phase
    wire        wrEdge  = psel & penable & pwrite;
    reg  [1:0]  rmReg; // 0 nearest, 1 toward zero
    reg  [4:0]  flagReg; // sticky exception flags
    reg  [4:0]  enableReg; // trap enables
    reg  [5:0]  causeReg; // cause of last instruction
    reg         dnReg; // denormal_as_zero_bit
    reg         prReg; // precision_mode_bit
    reg  [63:0] destReg; // double_dest_pair / single
    reg  [63:0] srcReg; // double_src_pair / single
    reg  [31:0] pcReg; // program counter image
    reg  [1:0]  irqStatReg; // bit0 done, bit1 trap
    reg  [1:0]  irqEnReg; // interrupt enables
    reg         trapReg; // last instruction trapped
    // latched instruction
    reg  [1:0]  opReg; // 0 add, 1 eq, 2 gt
    reg         opPrecReg;
    reg         opDnReg;
    reg         opRmReg;
    reg  [2:0]  cntReg; // execution states left

    assign pready = 1'b1; // zero wait states
    assign irq    = |(irqStatReg & irqEnReg);

    // command decode: only the three supported encodings start work
    wire [3:0] lowNib  = pwdata[3:0];
    wire       cmdOk   = (pwdata[15:12] == `OPC_PREFIX) &&
                         (lowNib == `OPC_ADD || lowNib == `OPC_CMP_EQ ||
                          lowNib == `OPC_CMP_GT);
    wire       startCmd = wrEdge && paddr == `OFF_COMMAND && cmdOk && !busy;
    wire       commit   = busy && cntReg == 3'd1;

    // operand classes from the latched instruction mode
    wire [2:0] clsM = classify(srcReg, opPrecReg, opDnReg);
    wire [2:0] clsN = classify(destReg, opPrecReg, opDnReg);
    wire sM = opPrecReg ? srcReg[63]  : srcReg[31];
    wire sN = opPrecReg ? destReg[63] : destReg[31];
    wire anySnan = clsM == `CLS_SNAN || clsN == `CLS_SNAN;
    wire anyQnan = clsM == `CLS_QNAN || clsN == `CLS_QNAN;
    wire [63:0] qnanVal = opPrecReg ? `QNAN_DOUBLE : {32'h0, `QNAN_SINGLE};

    // normal-operand adder: unpack into double-biased internal form
    reg [11:0] eaNext, ebNext, xe, ye, dExp;
    reg [52:0] maNext, mbNext, xm, ym;
    reg        xs, ys, big;
    reg [55:0] ext, shifted, lostMask, aligned, nm;
    reg [56:0] sum;
    reg [5:0]  lz;
    reg [12:0] ne, be, emax;
    reg        rb, st, lsb, up, inexact;
    reg [53:0] mt, inc, mr;
    reg [63:0] sumNext; // packed rounded sum
    reg [2:0]  sumExcNext; // {O,U,I}
    always @* begin
        eaNext = opPrecReg ? {1'b0, srcReg[62:52]}
                           : ({4'h0, srcReg[30:23]} + `REBIAS);
        ebNext = opPrecReg ? {1'b0, destReg[62:52]}
                           : ({4'h0, destReg[30:23]} + `REBIAS);
        maNext = opPrecReg ? {1'b1, srcReg[51:0]}
                           : {1'b1, srcReg[22:0], 29'h0};
        mbNext = opPrecReg ? {1'b1, destReg[51:0]}
                           : {1'b1, destReg[22:0], 29'h0};
        // larger magnitude goes first so the difference stays positive
        big = (eaNext > ebNext) || (eaNext == ebNext && maNext >= mbNext);
        xe = big ? eaNext : ebNext;
        ye = big ? ebNext : eaNext;
        xm = big ? maNext : mbNext;
        ym = big ? mbNext : maNext;
        xs = big ? sM : sN;
        ys = big ? sN : sM;
        dExp = xe - ye;
        ext = {ym, 3'b000};
        shifted = 56'h0;
        lostMask = 56'h0;
        // guard, round and sticky bits keep the shifted-out part
        if (dExp >= 12'd56) begin
            aligned = {55'h0, 1'b1};
        end else begin
            shifted  = ext >> dExp[5:0];
            lostMask = ~({56{1'b1}} << dExp[5:0]);
            aligned  = {shifted[55:1], shifted[0] | (|(ext & lostMask))};
        end
        if (xs ^ ys)
            sum = {1'b0, xm, 3'b000} - {1'b0, aligned};
        else
            sum = {1'b0, xm, 3'b000} + {1'b0, aligned};
        // normalise: carry shifts right, cancellation shifts left
        lz = lzc56(sum[55:0]);
        if (sum[56]) begin
            nm = {sum[56:2], sum[1] | sum[0]};
            ne = {1'b0, xe} + 13'd1;
        end else begin
            nm = sum[55:0] << lz;
            ne = {1'b0, xe} - {7'h0, lz};
        end
        // rounding point depends on precision
        rb  = opPrecReg ? nm[2] : nm[31];
        st  = opPrecReg ? (|nm[1:0]) : (|nm[30:0]);
        lsb = opPrecReg ? nm[3] : nm[32];
        inexact = rb | st;
        up  = ~opRmReg & rb & (st | lsb);
        mt  = opPrecReg ? {1'b0, nm[55:3]} : {1'b0, nm[55:32], 29'h0};
        inc = opPrecReg ? 54'h1 : 54'h2000_0000;
        mr  = mt + (up ? inc : 54'h0);
        if (mr[53]) begin
            mr = mr >> 1;
            ne = ne + 13'd1;
        end
        be   = opPrecReg ? ne : (ne - `REBIAS);
        emax = opPrecReg ? `EMAX_DOUBLE : `EMAX_SINGLE;
        sumExcNext = {1'b0, 1'b0, inexact};
        if (sum == 57'h0) begin
            sumNext = 64'h0; // exact cancel: +0
            sumExcNext = 3'b000;
        end else if (!be[12] && be >= emax) begin // RULE19
            sumExcNext = 3'b101;
            if (opRmReg)
                sumNext = opPrecReg ? {xs, 63'h7fef_ffff_ffff_ffff}
                                    : {32'h0, xs, 31'h7f7f_ffff};
            else
                sumNext = opPrecReg ? {xs, 63'h7ff0_0000_0000_0000}
                                    : {32'h0, xs, 31'h7f80_0000};
        end else if (be[12] || be == 13'd0) begin // RULE19
            // no denormal outputs: flush to a signed zero
            sumExcNext = 3'b011;
            sumNext = opPrecReg ? {xs, 63'h0} : {32'h0, xs, 31'h0};
        end else begin
            sumNext = opPrecReg ? {xs, be[10:0], mr[51:0]}
                                : {32'h0, xs, be[7:0], mr[51:29]};
        end
    end

    // add outcome: special cases first, then the rounded sum
    reg [63:0] addResNext;
    reg [5:0]  addCauseNext;
    reg        addWriteNext;
    always @* begin
        addResNext   = destReg;
        addCauseNext = 6'h00;
        addWriteNext = 1'b1;
        if (anySnan) begin // RULE6
            addCauseNext[`EXC_V] = 1'b1;
            addResNext = qnanVal;
        end else if (anyQnan) begin // RULE6
            addResNext = qnanVal;
        end else if (clsM == `CLS_DENORM || clsN == `CLS_DENORM) begin
            addCauseNext[`EXC_E] = 1'b1; // RULE7
            addWriteNext = 1'b0;
        end else if (clsM == `CLS_INF && clsN == `CLS_INF && sM != sN) begin
            addCauseNext[`EXC_V] = 1'b1; // RULE8
            addResNext = qnanVal;
        end else if (clsM == `CLS_INF) begin // RULE8
            addResNext = srcReg;
        end else if (clsN == `CLS_INF) begin // RULE8
            addResNext = destReg;
        end else if (clsM == `CLS_ZERO && clsN == `CLS_ZERO) begin
            // mixed signs give +0, equal signs keep it
            addResNext = opPrecReg ? {sM & sN, 63'h0} // RULE9
                                   : {32'h0, sM & sN, 31'h0};
        end else if (clsN == `CLS_ZERO) begin // RULE9
            addResNext = srcReg;
        end else if (clsM == `CLS_ZERO) begin // RULE9
            addResNext = destReg;
        end else begin
            addResNext = sumNext; // RULE19
            addCauseNext[`EXC_O] = sumExcNext[2];
            addCauseNext[`EXC_U] = sumExcNext[1];
            addCauseNext[`EXC_I] = sumExcNext[0];
        end
    end

    // compare outcome on sign-magnitude values
    reg [62:0] magM, magN;
    reg        cmpEq, cmpGt;
    always @* begin
        magM = opPrecReg ? srcReg[62:0]  : {32'h0, srcReg[30:0]};
        magN = opPrecReg ? destReg[62:0] : {32'h0, destReg[30:0]};
        if (clsM == `CLS_ZERO)
            magM = 63'h0;
        if (clsN == `CLS_ZERO)
            magN = 63'h0;
        // both zeros equal whatever the signs
        cmpEq = (magM == magN) && (sM == sN || magM == 63'h0); // RULE16 RULE18
        if (cmpEq)
            cmpGt = 1'b0;
        else if (sN != sM)
            cmpGt = ~sN; // RULE17
        else
            cmpGt = sN ? (magN < magM) : (magN > magM); // RULE18
    end

    // trap decision and write enables at the end of execution
    wire enV      = enableReg[`EXC_V];
    wire cmpInval = anySnan || (opReg == 2'd2 && anyQnan); // RULE13 RULE14
    // O/U/I enables force a trap on every add
    wire addTrap  = addCauseNext[`EXC_E] || (addCauseNext[`EXC_V] && enV) ||
                    (|enableReg[`EXC_O:`EXC_I]); // RULE3
    wire cmpTrap  = cmpInval && enV;
    wire trapNow  = (opReg == 2'd0) ? addTrap : cmpTrap;
    // only E, V, O, U and I can be raised by an add
    wire [5:0] causeNow = (opReg == 2'd0) ? (addCauseNext & 6'h37) // RULE10
                        : {1'b0, cmpInval, 4'h0};

    // apb read data and error, captured in the setup phase
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= 1'b0;
            case (paddr)
                `OFF_STATUS_CTRL:
                    prdata <= {12'h0, prReg, dnReg, causeReg, enableReg,
                               flagReg, rmReg};
                `OFF_DEST_HI:      prdata <= destReg[63:32];
                `OFF_DEST_LO:      prdata <= destReg[31:0];
                `OFF_SRC_HI:       prdata <= srcReg[63:32];
                `OFF_SRC_LO:       prdata <= srcReg[31:0];
                `OFF_COMMAND:      prdata <= 32'h0;
                `OFF_UNIT_STATE:   prdata <= {29'h0, trapReg, condBit, busy};
                `OFF_PROG_COUNTER: prdata <= pcReg;
                `OFF_IRQ_STATUS:   prdata <= {30'h0, irqStatReg};
                `OFF_IRQ_ENABLE:   prdata <= {30'h0, irqEnReg};
                `OFF_IRQ_CLEAR:    prdata <= 32'h0;
                default: begin
                    prdata  <= 32'h0;
                    pslverr <= 1'b1;          // unmapped address
                end
            endcase
        end
    end

    // register writes, instruction start and commit
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {prReg, dnReg, causeReg, enableReg, flagReg, rmReg}
                       <= `RESET_STATUS;
            destReg    <= 64'h0;
            srcReg     <= 64'h0;
            pcReg      <= 32'h0;
            irqStatReg <= 2'b00;
            irqEnReg   <= 2'b00;
            trapReg    <= 1'b0;
            opReg      <= 2'd0;
            opPrecReg  <= 1'b0;
            opDnReg    <= 1'b0;
            opRmReg    <= 1'b0;
            cntReg     <= 3'd0;
            busy       <= 1'b0;
            condBit    <= 1'b0;
        end else begin
            // software writes; operands are frozen while busy
            if (wrEdge) begin
                case (paddr)
                    `OFF_STATUS_CTRL: begin
                        {prReg, dnReg, causeReg, enableReg, flagReg, rmReg}
                            <= pwdata[19:0];
                    end
                    `OFF_DEST_HI:
                        if (!busy) destReg[63:32] <= pwdata;
                    `OFF_DEST_LO:
                        if (!busy) destReg[31:0] <= pwdata;
                    `OFF_SRC_HI:
                        if (!busy) srcReg[63:32] <= pwdata;
                    `OFF_SRC_LO:
                        if (!busy) srcReg[31:0] <= pwdata;
                    `OFF_PROG_COUNTER:
                        if (!busy) pcReg <= pwdata;
                    `OFF_IRQ_ENABLE:   irqEnReg <= pwdata[1:0];
                    `OFF_IRQ_CLEAR:    irqStatReg <= irqStatReg & ~pwdata[1:0];
                    default: ;
                endcase
            end
            if (startCmd) begin
                causeReg  <= 6'h00; // RULE5
                pcReg     <= pcReg + `PC_STEP; // RULE5
                opPrecReg <= prReg;
                opDnReg   <= dnReg;
                opRmReg   <= rmReg[0];
                busy      <= 1'b1;
                case (lowNib)
                    `OPC_ADD: begin
                        opReg  <= 2'd0;
                        cntReg <= prReg ? `STATES_ADD_DOUBLE // RULE2
                                        : `STATES_ADD_SINGLE; // RULE1
                    end
                    `OPC_CMP_EQ: begin
                        opReg  <= 2'd1;
                        cntReg <= `STATES_CMP_EQ; // RULE11
                    end
                    default: begin
                        opReg  <= 2'd2;
                        cntReg <= `STATES_CMP_GT; // RULE12
                    end
                endcase
            end else if (commit) begin
                busy     <= 1'b0;
                cntReg   <= 3'd0;
                trapReg  <= trapNow;
                // cause and sticky flags recorded, set beats a write  RULE4
                causeReg <= causeNow;
                flagReg  <= (wrEdge && paddr == `OFF_STATUS_CTRL ?
                             pwdata[`FLAG_HI:`FLAG_LO] : flagReg) |
                            causeNow[4:0];
                if (opReg == 2'd0) begin
                    if (addWriteNext && !trapNow) // RULE4
                        destReg <= addResNext; // RULE1 RULE2
                end else if (!trapNow) begin
                    if (cmpInval)
                        condBit <= 1'b0; // RULE13
                    else if (opReg == 2'd1)
                        condBit <= cmpEq && !anyQnan; // RULE15
                    else
                        condBit <= cmpGt; // RULE12
                end
                // events: done and trap; a set beats a clear
                irqStatReg <= (wrEdge && paddr == `OFF_IRQ_CLEAR ?
                               irqStatReg & ~pwdata[1:0] : irqStatReg) |
                              {trapNow, 1'b1};
            end else if (busy) begin
                cntReg <= cntReg - 3'd1;
            end
        end
    end

endmodule // fpu_add_compare_unit

// [testbench/fpu_add_compare_unit_asserts.sv]
// Purpose: port timing checks of the add/compare unit
// Assumes: one clock, async active-high reset
// Notes:   precision is mirrored from software writes
`timescale 1ns/10ps
`include "fpu_add_compare_consts.vh"
module fpu_add_compare_unit_asserts (
    // clock and reset
    input wire        ref_clk,
    input wire        sys_rst,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // unit status
    input wire        irq,
    input wire        busy,
    input wire        condBit
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire       wrAcc = psel && penable && pwrite; // write lands now
    // accepted command; a bad low nibble only weakens the checks
    wire       take = wrAcc && !busy && paddr == `OFF_COMMAND
        && pwdata[15:12] == `OPC_PREFIX;
    wire [3:0] op = pwdata[3:0];
    reg        precReg; // precision mode as software left it
    // only software writes move the precision bit
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            precReg <= 1'b0;
        else if (wrAcc && paddr == `OFF_STATUS_CTRL)
            precReg <= pwdata[`PR_BIT];
    end
    a_add_single: assert property (take && op == 4'h0 && !precReg
        |=> busy ##1 !busy) else $error("single add length wrong");
    a_add_double: assert property (take && op == 4'h0 && precReg
        |=> busy[*6] ##1 !busy) else $error("double add length wrong");
    a_eq_one: assert property (take && op == 4'h4
        |=> busy ##1 !busy) else $error("equal compare length wrong");
    a_gt_two: assert property (take && op == 4'h5
        |=> busy[*2] ##1 !busy) else $error("greater length wrong");
    a_busy_cause: assert property ($rose(busy) |-> $past(take))
        else $error("busy rose without a command");
    a_idle_stays: assert property (!busy && !take |=> !busy)
        else $error("busy rose on its own");
    a_add_keeps_cond: assert property (take && op == 4'h0
        |=> $stable(condBit) until_with !busy)
        else $error("add moved the condition bit");
    a_cond_at_commit: assert property ($changed(condBit)
        |-> $fell(busy)) else $error("condition bit moved off commit");
    a_irq_source: assert property ($rose(irq)
        |-> $fell(busy) || $past(wrAcc)) else $error("irq rose unprompted");
    c_add_double: cover property (take && op == 4'h0 && precReg);
    c_gt: cover property (take && op == 4'h5);
    c_irq: cover property ($rose(irq));
endmodule // fpu_add_compare_unit_asserts
bind fpu_add_compare_unit fpu_add_compare_unit_asserts
    i_fpu_add_compare_unit_asserts (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .busy(busy), .condBit(condBit));

// [testbench/host_core_model.sv]
// Purpose: host core side, issues apb transfers to the unit
// Assumes: slave answers through pready
// Notes:   released write data is inverted so stale data never matches
`timescale 1ns/10ps
module host_core_model (
    // clock
    input  wire         ref_clk,
    // apb master
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [7:0]  paddr,
    output logic [31:0] pwdata,
    input  wire  [31:0] prdata,
    input  wire         pready
);
    int timeouts = 0; // transfers never answered
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // setup, then access held until pready is seen high
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64)
            timeouts++;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule // host_core_model

// [testbench/fpu_add_compare_unit_tb.sv]
// Purpose: directed add and compare sequences over apb
// Assumes: operands staged in dest/src registers, then a command
// Notes:   single operands sit in the low words
`timescale 1ns/10ps
`include "fpu_add_compare_consts.vh"
module fpu_add_compare_unit_tb;
    logic        ref_clk;
    logic        sys_rst;
    wire         psel, penable, pwrite, pready, pslverr, irq, busy, condBit;
    wire  [7:0]  paddr;
    wire  [31:0] pwdata, prdata;
    logic [31:0] q;
    int          errors, checks_done;
    localparam logic [63:0] oneS = 64'h3f800000; // single 1.0
    always #5 ref_clk = ~ref_clk;
    fpu_add_compare_unit i_fpu_add_compare_unit (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .busy(busy), .condBit(condBit));
    host_core_model i_host_core_model (.ref_clk(ref_clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready));
    task stop_test;
        errors += i_host_core_model.timeouts;
        if (errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        i_host_core_model.xfer(1'b1, a, d, q);
    endtask
    // read, keep the masked bits, compare
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        i_host_core_model.xfer(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask
    task dl(input logic [31:0] e);
        rd(`OFF_DEST_LO, '1, e);
    endtask
    task cz(input logic [31:0] e);
        rd(`OFF_STATUS_CTRL, 32'h3f000, e);
    endtask
    // irq sampled mid-cycle, after updates landed
    task irqIs(input logic e);
        @(negedge ref_clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    // stage operands, issue one command, poll until idle
    task exe(input logic [31:0] st, input logic [3:0] op,
             input logic [63:0] dv, input logic [63:0] sv);
        int n;
        wr(`OFF_STATUS_CTRL, st);
        wr(`OFF_DEST_HI, dv[63:32]);
        wr(`OFF_DEST_LO, dv[31:0]);
        wr(`OFF_SRC_HI, sv[63:32]);
        wr(`OFF_SRC_LO, sv[31:0]);
        wr(`OFF_COMMAND, {16'h0, `OPC_PREFIX, 8'h00, op});
        n = 0;
        do begin
            i_host_core_model.xfer(1'b0, `OFF_UNIT_STATE, 32'h0, q);
            n++;
        end while (q[0] !== 1'b0 && n < 20);
        if (n >= 20) begin
            errors++;
            stop_test();
        end
    endtask
    // compare, then check the condition output
    task cc(input logic [31:0] st, input logic [3:0] op,
            input logic [63:0] dv, input logic [63:0] sv, input logic e);
        exe(st, op, dv, sv);
        chk({31'h0, condBit}, {31'h0, e});
    endtask
    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        errors = 0;
        checks_done = 0;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`OFF_IRQ_ENABLE, '1, 32'h0);
        rd(8'h40, '1, 32'h0); // unmapped place reads zero
        chk({31'h0, pslverr}, 32'h1); // and answers with an error
        exe('0, 4'h0, oneS, 64'h40000000);
        dl(32'h40400000);
        rd(`OFF_PROG_COUNTER, '1, 32'h2);
        exe(32'h80000, 4'h0, 64'h3ff0000000000000, 64'h3ff0000000000000);
        rd(`OFF_DEST_HI, '1, 32'h40000000);
        dl(32'h0);
        exe('0, 4'h0, 64'h7fc00000, oneS);
        dl(32'h7fbfffff);
        rd(`OFF_STATUS_CTRL, 32'h3f07c, 32'h10040);
        exe('0, 4'h0, 64'h7f800001, oneS);
        rd(`OFF_DEST_LO, 32'h7fc00000, 32'h7f800000);
        cz(32'h0);
        exe('0, 4'h0, 64'h7f800000, 64'hff800000);
        dl(32'h7fbfffff);
        exe('0, 4'h0, 64'hff800000, oneS);
        dl(32'hff800000);
        exe('0, 4'h0, 64'h80000000, 64'h0);
        dl(32'h0);
        exe('0, 4'h0, 64'h80000000, 64'h80000000);
        dl(32'h80000000);
        exe('0, 4'h0, 64'h0, 64'hc0000000);
        dl(32'hc0000000);
        exe('0, 4'h0, 64'h7f7fffff, 64'h7f7fffff);
        dl(32'h7f800000);
        cz(32'h5000);
        exe(32'h1, 4'h0, 64'h7f7fffff, 64'h7f7fffff);
        dl(32'h7f7fffff);
        wr(`OFF_IRQ_CLEAR, 32'h3);
        wr(`OFF_IRQ_ENABLE, 32'h2);
        exe('0, 4'h0, 64'h1, oneS);
        dl(32'h1);
        cz(32'h20000);
        irqIs(1'b1);
        wr(`OFF_IRQ_CLEAR, 32'h3);
        irqIs(1'b0);
        exe(32'h40000, 4'h0, 64'h1, oneS);
        dl(32'h3f800000);
        exe(32'h200, 4'h0, oneS, 64'h40000000);
        dl(32'h3f800000);
        irqIs(1'b1);
        wr(`OFF_IRQ_ENABLE, 32'h0);
        irqIs(1'b0);
        wr(`OFF_IRQ_CLEAR, 32'h3);
        cc('0, 4'h4, oneS, oneS, 1'b1);
        cc('0, 4'h4, 64'h7f800001, oneS, 1'b0);
        cz(32'h0);
        cc('0, 4'h4, 64'h80000000, 64'h0, 1'b1);
        cc('0, 4'h5, 64'h40000000, oneS, 1'b1);
        cc('0, 4'h5, oneS, 64'h40000000, 1'b0);
        cc('0, 4'h5, 64'h7f800001, oneS, 1'b0);
        cz(32'h10000);
        cc('0, 4'h5, 64'h7f800000, oneS, 1'b1);
        cc('0, 4'h5, 64'hff800000, oneS, 1'b0);
        cc('0, 4'h4, 64'h7f800000, 64'h7f800000, 1'b1);
        cc('0, 4'h4, 64'h7fc00000, oneS, 1'b0);
        cc(32'h800, 4'h5, 64'h7fc00000, 64'h0, 1'b0);
        rd(`OFF_UNIT_STATE, 32'h4, 32'h4);
        cc('0, 4'h5, 64'hbf800000, 64'hc0000000, 1'b1);
        cc(32'h80000, 4'h5, 64'h3ff0000000000001,
           64'h3ff0000000000000, 1'b1);
        stop_test();
    end
endmodule // fpu_add_compare_unit_tb
